// [hdl/eepc_array_mem.v]
`timescale 1ns/10ps
`include "eepc_consts.vh"

module eepc_array_mem (
    input wire ref_clk,
    input wire [9:0] rd_addr,
    output reg [7:0] rd_data,
    input wire wr_en,
    input wire [9:0] wr_addr,
    input wire [7:0] wr_data
);

reg [7:0] mem [0:`EEPC_MEM_WORDS-1];
integer i;

// array starts in the erased state
initial begin
    for (i = 0; i < `EEPC_MEM_WORDS; i = i + 1) begin
        mem[i] = `EEPC_ERASED;
    end
end

always @(posedge ref_clk) begin
    if (wr_en) begin
        mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
end

endmodule

// [hdl/eepc_ctrl.v]
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "eepc_consts.vh"

// Behaviour
// R1: pump clock select bit picks bus clock (1) or rc oscillator (0); reset clears.
// R2: software keeps rc oscillator as pump clock below 8 MHz bus rate.
// R3: power-down bit disables array, reads unpredictable; 0 enables; reset clears.
// R4: software waits a recovery time after clearing power-down before access.
// R5: erase-select 00 program, 01 byte, 10 block, 11 bulk erase; reset clears.
// R6: protected block gets no program or erase regardless of erase-select.
// R7: latch bit captures address/data; cannot clear while hv enable set; reset clears.
// R8: hv enable powers pump only with latch set and a valid array write.
// R9: one write clearing latch and hv enable clears only hv enable.
// R10: shadow register is read-only, 8 bits, loaded from config byte at reset.
// R11: software keeps the redundancy bit of the config byte at zero.
// R12: security config bit 1 disables security, 0 enables; other two unused.
// R13: four protect bits load from config byte at reset; 1 protects block.
// R14: wait mode does not disturb the array; operations continue.
// R15: stop mode drops high voltage, enable bit stays; restored on stop exit.
// R16: software should not enter stop with hv enable set.
// R17: software extends program/erase time after a stop interruption.
// R18: software waits a recovery time after stop before array access.
// R19: 512 bytes form four 128-byte blocks, protect bits in address order.
// R20: later valid write replaces latch; array reads return latched data.
// R21: each read of the config byte reloads the shadow register.
// R22: with security on, block/bulk erase and config byte changes are refused.
module eepc_ctrl #(
    parameter [15:0] OP_CYCLES = `EEPC_OP_CYCLES
) (
    input wire ref_clk,
    input wire srst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [15:0] wb_adr_i,
    input wire [0:0] wb_sel_i,
    input wire [7:0] wb_dat_i,
    output reg [7:0] wb_dat_o,
    output reg wb_ack_o,
    input wire stop_mode,
    output wire pump_clk_bus_sel,
    output wire array_power_down,
    output wire hv_on,
    output wire security_on,
    output wire op_busy
);

localparam ST_IDLE = 2'd0;
localparam ST_HOLD = 2'd1;
localparam ST_APPLY = 2'd2;
localparam ST_DONE = 2'd3;

////////////////////////////////////////////////////////////////////////
// address decode helpers

function is_array;
    input [15:0] a;
    begin
        is_array = (a[15:9] == `EEPC_ARRAY_BASE_HI);
    end
endfunction

function [9:0] mem_index;
    input [15:0] a;
    begin
        if (is_array(a)) begin
            mem_index = {1'b0, a[8:0]};
        end else begin
            mem_index = `EEPC_CFG_IDX;
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////
// state

reg pump_clk_q;
reg power_down_q;
reg [1:0] ers_q;
reg latch_q;
reg hv_en_q;
reg wr_valid_q;
reg [9:0] lat_idx_q;
reg [7:0] lat_data_q;
reg [7:0] shadow_q;
reg [1:0] boot_q;
reg pend_q;
reg [1:0] st_q;
reg [15:0] cnt_q;
reg [9:0] step_q;

wire [7:0] rd_data;
wire req = wb_cyc_i & wb_stb_i;
wire wr_take = req & wb_we_i & wb_sel_i[0] & wb_ack_o;
wire ctrl_wr = wr_take & (wb_adr_i == `EEPC_ADDR_CTRL);
wire [7:0] ctrl_rd = {pump_clk_q, 2'b00, power_down_q, ers_q, latch_q, hv_en_q};

assign pump_clk_bus_sel = pump_clk_q; // [R1]
assign array_power_down = power_down_q; // [R3]
assign security_on = ~shadow_q[`EEPC_SH_SECURITY]; // [R12]
assign op_busy = (st_q == ST_HOLD) | (st_q == ST_APPLY);

////////////////////////////////////////////////////////////////////////
// permission for the latched target

reg tgt_cfg;
reg blk_prot;
reg op_allowed;

always @* begin
    tgt_cfg = (lat_idx_q == `EEPC_CFG_IDX);
    blk_prot = shadow_q[lat_idx_q[8:7]]; // [R19]
    if (tgt_cfg) begin
        // block and bulk erase leave the config byte alone
        op_allowed = ~ers_q[1] & ~security_on; // [R22]
    end else begin
        case (ers_q)
            `EEPC_MODE_BULK_ERASE: op_allowed = (shadow_q[3:0] == 4'h0) & ~security_on; // [R6] [R22]
            `EEPC_MODE_BLOCK_ERASE: op_allowed = ~blk_prot & ~security_on; // [R6] [R22]
            default: op_allowed = ~blk_prot; // [R6] [R5]
        endcase
    end
end

// wait mode is not an input: the array keeps working through it [R14]
assign hv_on = hv_en_q & latch_q & wr_valid_q & op_allowed & ~stop_mode; // [R8] [R15]

////////////////////////////////////////////////////////////////////////
// valid array write for the latch

wire wr_hit_arr = is_array(wb_adr_i);
wire wr_hit_cfg = (wb_adr_i == `EEPC_ADDR_NVCFG);
wire wr_secure = (wb_adr_i >= `EEPC_SECURE_LO) & (wb_adr_i <= `EEPC_SECURE_HI);
wire valid_wr = wr_take & latch_q & ~hv_en_q
              & ((wr_hit_arr & ~(security_on & wr_secure)) | (wr_hit_cfg & ~security_on)); // [R22]

////////////////////////////////////////////////////////////////////////
// control register

always @(posedge ref_clk) begin
    if (srst) begin
        pump_clk_q <= 1'b0; // [R1]
        power_down_q <= 1'b0; // [R3]
        ers_q <= 2'b00; // [R5]
        latch_q <= 1'b0; // [R7]
        hv_en_q <= 1'b0; // [R8]
        wr_valid_q <= 1'b0;
        lat_idx_q <= 10'h000;
        lat_data_q <= 8'h00;
    end else begin
        if (ctrl_wr) begin
            pump_clk_q <= wb_dat_i[`EEPC_CTRL_PUMP_CLK]; // [R1]
            power_down_q <= wb_dat_i[`EEPC_CTRL_POWER_DOWN]; // [R3]
            // mode is frozen while high voltage is enabled
            if (!hv_en_q) begin
                ers_q <= wb_dat_i[`EEPC_CTRL_ERS_HI:`EEPC_CTRL_ERS_LO]; // [R5]
            end
            // enable only takes once the latch holds a valid write
            hv_en_q <= wb_dat_i[`EEPC_CTRL_HV_EN] & latch_q & wr_valid_q; // [R8]
            // latch survives any write made while enable is still set
            latch_q <= hv_en_q | wb_dat_i[`EEPC_CTRL_LATCH]; // [R7] [R9]
            if (!(hv_en_q | wb_dat_i[`EEPC_CTRL_LATCH])) begin
                wr_valid_q <= 1'b0;
            end
        end else if (valid_wr) begin
            lat_idx_q <= mem_index(wb_adr_i); // [R20]
            lat_data_q <= wb_dat_i; // [R20]
            wr_valid_q <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// high-voltage sequencer: hold, then change the array

wire [9:0] last_idx = (ers_q == `EEPC_MODE_BULK_ERASE) ? 10'h1ff :
                      (ers_q == `EEPC_MODE_BLOCK_ERASE) ? {lat_idx_q[9:7], 7'h7f} : lat_idx_q;
wire [9:0] first_idx = (ers_q == `EEPC_MODE_BULK_ERASE) ? 10'h000 :
                       (ers_q == `EEPC_MODE_BLOCK_ERASE) ? {lat_idx_q[9:7], 7'h00} : lat_idx_q;
wire mem_we = (st_q == ST_APPLY) & hv_on;
wire [7:0] mem_wdata = (ers_q == `EEPC_MODE_BYTE_PROG) ? lat_data_q : `EEPC_ERASED;

always @(posedge ref_clk) begin
    if (srst) begin
        st_q <= ST_IDLE;
        cnt_q <= 16'h0000;
        step_q <= 10'h000;
    end else begin
        case (st_q)
            ST_IDLE: begin
                cnt_q <= 16'h0000;
                if (hv_on) begin
                    st_q <= ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!hv_en_q) begin
                    st_q <= ST_IDLE;
                end else if (hv_on) begin
                    // stop only pauses the count, so time is lost, not reset [R15]
                    cnt_q <= cnt_q + 16'h0001;
                    if (cnt_q == OP_CYCLES - 16'h0001) begin
                        st_q <= ST_APPLY;
                        step_q <= first_idx;
                    end
                end
            end
            ST_APPLY: begin
                if (!hv_en_q) begin
                    st_q <= ST_IDLE;
                end else if (hv_on) begin
                    step_q <= step_q + 10'h001;
                    if (step_q == last_idx) begin
                        st_q <= ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                if (!hv_en_q) begin
                    st_q <= ST_IDLE;
                end
            end
            default: begin
                st_q <= ST_IDLE;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// array storage

wire [9:0] rd_idx = (boot_q != 2'd0) ? `EEPC_CFG_IDX : mem_index(wb_adr_i);

eepc_array_mem u_mem (
    .ref_clk(ref_clk),
    .rd_addr(rd_idx),
    .rd_data(rd_data),
    .wr_en(mem_we),
    .wr_addr(step_q),
    .wr_data(mem_wdata)
);

////////////////////////////////////////////////////////////////////////
// shadow register: loaded after reset and on config byte reads

wire cfg_rd = req & ~wb_we_i & pend_q & ~wb_ack_o & (wb_adr_i == `EEPC_ADDR_NVCFG);

always @(posedge ref_clk) begin
    if (srst) begin
        // safe value until the config byte has been fetched
        shadow_q <= `EEPC_SHADOW_RST;
        boot_q <= 2'd2;
    end else begin
        if (boot_q != 2'd0) begin
            boot_q <= boot_q - 2'd1;
        end
        if (boot_q == 2'd1) begin
            shadow_q <= rd_data; // [R10] [R13]
        end else if (cfg_rd) begin
            shadow_q <= rd_data; // [R21]
        end
    end
end

////////////////////////////////////////////////////////////////////////
// wishbone slave: two wait states, ack in the third cycle, covering the registered array read

reg [7:0] rd_mux;

always @* begin
    if (wb_adr_i == `EEPC_ADDR_CTRL) begin
        rd_mux = ctrl_rd;
    end else if (wb_adr_i == `EEPC_ADDR_SHADOW) begin
        rd_mux = shadow_q; // [R10]
    end else if (wb_adr_i == `EEPC_ADDR_NVCFG) begin
        rd_mux = rd_data;
    end else if (is_array(wb_adr_i)) begin
        if (power_down_q) begin
            rd_mux = `EEPC_ERASED; // [R3]
        end else if (latch_q & wr_valid_q) begin
            rd_mux = lat_data_q; // [R20]
        end else begin
            rd_mux = rd_data;
        end
    end else begin
        rd_mux = 8'h00;
    end
end

always @(posedge ref_clk) begin
    if (srst) begin
        pend_q <= 1'b0;
        wb_ack_o <= 1'b0;
        wb_dat_o <= 8'h00;
    end else begin
        pend_q <= req & ~pend_q & ~wb_ack_o & (boot_q == 2'd0);
        wb_ack_o <= req & pend_q & ~wb_ack_o;
        if (req & pend_q & ~wb_ack_o) begin
            wb_dat_o <= wb_we_i ? 8'h00 : rd_mux;
        end
    end
end

endmodule

// [pkg/eepc_consts.vh]
`ifndef EEPC_CONSTS_VH
`define EEPC_CONSTS_VH

// bus map, byte addresses on a 16-bit address, 8-bit data
`define EEPC_ARRAY_BASE_HI 7'h04
`define EEPC_ADDR_CTRL 16'hfe1d
`define EEPC_ADDR_NVCFG 16'hfe1c
`define EEPC_ADDR_SHADOW 16'hfe1f
`define EEPC_SECURE_LO 16'h08f0
`define EEPC_SECURE_HI 16'h08ff

// memory word holding the nonvolatile configuration byte
`define EEPC_CFG_IDX 10'h200
`define EEPC_MEM_WORDS 513
`define EEPC_ERASED 8'hff

// control register fields
`define EEPC_CTRL_PUMP_CLK 7
`define EEPC_CTRL_POWER_DOWN 4
`define EEPC_CTRL_ERS_HI 3
`define EEPC_CTRL_ERS_LO 2
`define EEPC_CTRL_LATCH 1
`define EEPC_CTRL_HV_EN 0

// shadow register fields
`define EEPC_SH_REDUNDANCY 7
`define EEPC_SH_SECURITY 4
`define EEPC_SH_PROT_HI 3
`define EEPC_SH_PROT_LO 0
`define EEPC_SHADOW_RST 8'hff

// erase-select encodings
`define EEPC_MODE_BYTE_PROG 2'b00
`define EEPC_MODE_BYTE_ERASE 2'b01
`define EEPC_MODE_BLOCK_ERASE 2'b10
`define EEPC_MODE_BULK_ERASE 2'b11

// cycles of high voltage before the array is changed
`define EEPC_OP_CYCLES 16'd64

`endif

// [verification/eepc_ctrl_chk.sv]
`timescale 1ns/10ps
`include "eepc_consts.vh"
module eepc_ctrl_chk (
    input wire ref_clk,
    input wire srst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [15:0] wb_adr_i,
    input wire [0:0] wb_sel_i,
    input wire [7:0] wb_dat_i,
    input wire [7:0] wb_dat_o,
    input wire wb_ack_o,
    input wire stop_mode,
    input wire pump_clk_bus_sel,
    input wire array_power_down,
    input wire hv_on,
    input wire security_on
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire rd_ack = wb_ack_o && !wb_we_i;
    wire wr_cr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `EEPC_ADDR_CTRL;
    wire arr = wb_adr_i[15:9] == `EEPC_ARRAY_BASE_HI;
    wire regs = wb_adr_i == `EEPC_ADDR_CTRL || wb_adr_i == `EEPC_ADDR_NVCFG || wb_adr_i == `EEPC_ADDR_SHADOW;
    ////////////////////////////////////////////////////////////////////////////////
    a_ack_latency: assert property ($rose(wb_cyc_i && wb_stb_i) |-> !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o)
        else $error("ack latency wrong");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_dat_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o) else $error("read data moved");
    a_pump_write: assert property (wr_cr |=> pump_clk_bus_sel == $past(wb_dat_i[7]))
        else $error("pump select not written");
    a_pd_write: assert property (wr_cr |=> array_power_down == $past(wb_dat_i[4]))
        else $error("power down not written");
    a_pd_read: assert property (rd_ack && arr && array_power_down |-> wb_dat_o == 8'hff)
        else $error("powered down read");
    a_ctrl_read: assert property (rd_ack && wb_adr_i == `EEPC_ADDR_CTRL |-> wb_dat_o[7] == pump_clk_bus_sel)
        else $error("control readback");
    a_shadow_sec: assert property (rd_ack && wb_adr_i == `EEPC_ADDR_SHADOW |-> security_on == !wb_dat_o[4])
        else $error("security flag");
    a_stop_hv: assert property (stop_mode |-> !hv_on) else $error("hv in stop");
    a_unmapped_zero: assert property (rd_ack && !arr && !regs |-> wb_dat_o == 8'h00) else $error("unmapped data");
    a_reset_clear: assert property (disable iff (1'b0) srst |=> !wb_ack_o && !pump_clk_bus_sel && !hv_on)
        else $error("reset state");
endmodule

// [verification/eepc_pump_model.sv]
`timescale 1ns/10ps
module eepc_pump_model (
    input logic ref_clk,
    input logic hv_on,
    input logic stop_req,
    output logic stop_mode,
    output int hv_cycles
);
    // stop only on the bench's command, never on its own
    initial stop_mode = 1'b0;
    initial hv_cycles = 0;
    // only pumped cycles are counted, so a stop gap adds nothing to the count
    always @(posedge ref_clk) begin
        stop_mode <= stop_req;
        if (hv_on) hv_cycles <= hv_cycles + 1;
    end
endmodule

// [verification/tb.sv]
`timescale 1ns/10ps
`include "eepc_consts.vh"
module tb;
    localparam int OPC = 4;
    localparam logic [15:0] CR = `EEPC_ADDR_CTRL;
    localparam logic [15:0] NV = `EEPC_ADDR_NVCFG;
    localparam logic [15:0] SH = `EEPC_ADDR_SHADOW;
    logic ref_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, stop_req, wb_ack_o, stop_mode;
    logic pump_clk_bus_sel, array_power_down, hv_on, security_on, op_busy;
    logic [15:0] wb_adr_i;
    logic [0:0] wb_sel_i;
    logic [7:0] wb_dat_i, wb_dat_o, d1, d2;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    int hv_cycles;
    logic [7:0] exp_q[$];
    logic [15:0] adr_q[$];
    eepc_ctrl #(.OP_CYCLES(16'(OPC))) eepc_ctrl_i (.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stop_mode(stop_mode), .pump_clk_bus_sel(pump_clk_bus_sel),
        .array_power_down(array_power_down), .hv_on(hv_on), .security_on(security_on), .op_busy(op_busy));
    eepc_pump_model eepc_pump_model_i (.ref_clk(ref_clk), .hv_on(hv_on), .stop_req(stop_req),
        .stop_mode(stop_mode), .hv_cycles(hv_cycles));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task done(input string nm);
        $display("%s done, pump cycles %0d", nm, hv_cycles);
    endtask
    task wb(input logic we, input logic [15:0] a, input logic [7:0] d, input logic s);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, s};
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge ref_clk);
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        wb(1'b1, a, d, 1'b1);
    endtask
    task rd(input logic [15:0] a, input logic [7:0] e);
        adr_q.push_back(a);
        exp_q.push_back(e);
        wb(1'b0, a, 8'h00, 1'b1);
    endtask
    // hv is cleared before the latch, so the latch must survive one write
    task op(input logic [1:0] m, input logic [15:0] a, input logic [7:0] d, input logic ok, v, stp);
        wr(CR, {4'h8, m, 2'b10}); // bus clock pumps, 50 MHz is above 8 MHz
        wr(a, d);
        wr(CR, {4'h8, m, 2'b11});
        chk("hv_on", hv_on, {7'h0, ok});
        // sequencer leaves idle at the edge after hv comes on, so look one edge later
        @(posedge ref_clk);
        chk("busy", op_busy, {7'h0, ok});
        if (stp) begin
            stop_req <= 1'b1;
            repeat (3) @(posedge ref_clk);
            chk("hv_in_stop", hv_on, 8'h00);
            chk("busy_in_stop", op_busy, 8'h01);
            rd(CR, 8'h83);
            stop_req <= 1'b0;
            repeat (2) @(posedge ref_clk); // recovery after stop
            chk("hv_after_stop", hv_on, {7'h0, ok});
        end
        repeat (OPC + 600) @(posedge ref_clk);
        chk("busy_done", op_busy, 8'h00);
        wr(CR, {4'h8, m, 2'b00});
        rd(CR, {4'h8, m, v, 1'b0});
        wr(CR, 8'h00);
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_fail++;
            give_verdict();
        end
    end
    always @(posedge ref_clk)
        if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i) chk($sformatf("read %h", adr_q.pop_front()), wb_dat_o, exp_q.pop_front());
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i, stop_req} = '0;
        srst = 1'b1;
        void'($urandom(4429));
        d1 = 8'($urandom) & 8'h7e;
        d2 = 8'($urandom) & 8'h3c;
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk("pump_sel", pump_clk_bus_sel, 8'h00);
        chk("power_down", array_power_down, 8'h00);
        rd(CR, 8'h00);
        rd(SH, 8'hff);
        rd(16'h1234, 8'h00);
        wb(1'b1, CR, 8'h90, 1'b0);
        rd(CR, 8'h00);
        wr(CR, 8'h90);
        rd(CR, 8'h90);
        chk("power_down", array_power_down, 8'h01);
        rd(16'h0800, 8'hff);
        wr(SH, 8'h00);
        rd(SH, 8'hff);
        wr(CR, 8'h00);
        repeat (8) @(posedge ref_clk); // recovery after power-up
        done("registers");
        wr(CR, 8'h02);
        wr(16'h0805, d2);
        wr(16'h0806, d1);
        rd(16'h0900, d1);
        wr(CR, 8'h00);
        rd(CR, 8'h00);
        wr(CR, 8'h02);
        wr(CR, 8'h03);
        rd(CR, 8'h02);
        wr(CR, 8'h00);
        op(2'b00, NV, 8'h70, 1'b1, 1'b1, 1'b0); // redundancy bit kept 0
        rd(NV, 8'h70);
        rd(SH, 8'h70);
        done("latch");
        op(2'b00, 16'h0805, d1, 1'b1, 1'b1, 1'b1);
        rd(16'h0805, d1);
        op(2'b00, 16'h0885, d2, 1'b1, 1'b1, 1'b0);
        op(2'b00, 16'h0905, d1, 1'b1, 1'b1, 1'b0);
        op(2'b01, 16'h0805, 8'h00, 1'b1, 1'b1, 1'b0);
        rd(16'h0805, 8'hff);
        op(2'b10, 16'h08a0, 8'h00, 1'b1, 1'b1, 1'b0);
        rd(16'h0885, 8'hff);
        rd(16'h0905, d1);
        op(2'b11, 16'h0800, 8'h00, 1'b1, 1'b1, 1'b0);
        rd(16'h0905, 8'hff);
        done("modes");
        op(2'b00, NV, 8'h71, 1'b1, 1'b1, 1'b0);
        rd(SH, 8'h70);
        rd(NV, 8'h71);
        rd(SH, 8'h71);
        op(2'b00, 16'h0810, d1, 1'b0, 1'b1, 1'b0);
        rd(16'h0810, 8'hff);
        op(2'b00, 16'h0890, d2, 1'b1, 1'b1, 1'b0);
        rd(16'h0890, d2);
        op(2'b00, NV, 8'h60, 1'b1, 1'b1, 1'b0);
        rd(NV, 8'h60);
        chk("secured", security_on, 8'h01);
        op(2'b10, 16'h0890, 8'h00, 1'b0, 1'b1, 1'b0);
        rd(16'h0890, d2);
        op(2'b00, NV, 8'h70, 1'b0, 1'b0, 1'b0);
        rd(NV, 8'h60);
        op(2'b00, 16'h08f5, d1, 1'b0, 1'b0, 1'b0);
        rd(16'h08f5, 8'hff);
        done("security");
        give_verdict();
    end
endmodule
bind eepc_ctrl eepc_ctrl_chk eepc_ctrl_chk_i (.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stop_mode(stop_mode), .pump_clk_bus_sel(pump_clk_bus_sel),
    .array_power_down(array_power_down), .hv_on(hv_on), .security_on(security_on));
